// File: i2coa_cmd_seq.sv
// command sequencer: start/restart/stop decisions per queued command
`default_nettype none
module i2coa_cmd_seq
  import i2coa_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic master_mode,
  input wire logic repeated_start_enable,
  input wire logic cmd_valid,
  input wire logic [CMD_W-1:0] cmd_data,
  input wire logic engine_ready,
  input wire logic engine_done,
  output logic cmd_take,
  output logic issue_restart,
  output logic issue_stop_start,
  output logic dir_read,
  output logic stop_after,
  output logic [7:0] tx_byte,
  output logic hold_scl_low
);
  typedef struct packed {
    i2coa_seq_t state;
    logic prev_dir;
    logic restart;
    logic stop_start;
    logic dir;
    logic stop;
    logic [7:0] data;
  } i2coa_sq_t;
  i2coa_sq_t s_q, s_d;
  logic new_dir;
  logic need_rs;

  assign cmd_take = cmd_valid && engine_ready;

  always_comb
  begin
    s_d = s_q;
    s_d.restart = 1'b0;
    s_d.stop_start = 1'b0;
    new_dir = master_mode ? cmd_data[BIT_CMD] : 1'b0;
    // restart bit is consumed with its command, never stored
    need_rs = (s_q.state != I2COA_IDLE) && (cmd_data[BIT_RESTART] || new_dir != s_q.prev_dir);
    unique case (s_q.state)
      I2COA_IDLE, I2COA_HOLD:
      begin
        if (cmd_take)
        begin
          s_d.restart = need_rs && repeated_start_enable;
          s_d.stop_start = need_rs && !repeated_start_enable;
          s_d.dir = new_dir;
          s_d.prev_dir = new_dir;
          s_d.stop = cmd_data[BIT_STOP];
          s_d.data = cmd_data[7:0];
          s_d.state = I2COA_BUSY;
        end
      end
      I2COA_BUSY:
      begin
        if (engine_done)
        begin
          // no stop and nothing queued: stall the bus, not release it
          s_d.state = s_q.stop ? I2COA_IDLE : I2COA_HOLD;
        end
      end
      default: s_d.state = I2COA_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign issue_restart = s_q.restart;
  assign issue_stop_start = s_q.stop_start;
  assign dir_read = s_q.dir;
  assign stop_after = s_q.stop;
  assign tx_byte = s_q.data;
  assign hold_scl_low = (s_q.state == I2COA_HOLD) && !cmd_valid;

  ////////////////////////////////////////////////////////////////////////////
  property p_rs_disabled;
    @(posedge clock) disable iff (reset) !repeated_start_enable |=> !issue_restart;
  endproperty
  a_rs_disabled: assert property (p_rs_disabled) else $error("restart issued while disabled");
  property p_forced_rs;
    @(posedge clock) disable iff (reset)
      cmd_take && s_q.state == I2COA_HOLD && cmd_data[BIT_RESTART] |=> issue_restart || issue_stop_start;
  endproperty
  a_forced_rs: assert property (p_forced_rs) else $error("forced restart not issued");
  property p_same_dir;
    @(posedge clock) disable iff (reset)
      cmd_take && !cmd_data[BIT_RESTART] && (master_mode ? cmd_data[BIT_CMD] : 1'b0) == s_q.prev_dir
      |=> !issue_restart && !issue_stop_start;
  endproperty
  a_same_dir: assert property (p_same_dir) else $error("needless restart");
  property p_hold;
    @(posedge clock) disable iff (reset)
      s_q.state == I2COA_BUSY && engine_done && !stop_after ##1 !cmd_valid |-> hold_scl_low;
  endproperty
  a_hold: assert property (p_hold) else $error("clock not held on empty fifo");
endmodule
`default_nettype wire

// File: i2coa_far.sv
// far-side model: transmit fifo, byte engine and receive fifo
`default_nettype none
module i2coa_far
  import i2coa_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic stall,
  input wire logic [3:0] lat,
  input wire logic tx_push_valid,
  input wire logic [CMD_W-1:0] tx_push_data,
  output logic tx_push_ready,
  output logic tx_valid,
  output logic [CMD_W-1:0] tx_data,
  input wire logic tx_pop,
  output logic engine_ready,
  output logic engine_done,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_first,
  input wire logic rx_pop,
  output logic rx_byte_done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [CMD_W-1:0] txq[$];
  logic [8:0] rxq[$];
  logic [4:0] cnt = 5'h0;
  logic rd = 1'h0;
  // empty fifo heads toggle every cycle so stale data never looks valid
  logic [CMD_W-1:0] junk = 11'h2aa;
  assign engine_ready = cnt == 5'h0 && !engine_done && !stall;
  ////////////////////////////////////////////////////////////////////////
  task automatic rx_put(input logic [8:0] v);
    rxq.push_back(v);
  endtask
  always @(posedge clock)
  begin
    junk <= ~junk;
    if (reset)
    begin
      txq.delete();
      rxq.delete();
      cnt <= 5'h0;
    end
    else
    begin
      if (tx_push_valid && tx_push_ready)
        txq.push_back(tx_push_data);
      if (tx_pop)
      begin
        rd <= txq[0][BIT_CMD];
        void'(txq.pop_front());
        // byte time varies so both prompt and slow answers occur
        cnt <= 5'h2 + 5'(lat);
      end
      else if (cnt != 5'h0)
        cnt <= cnt - 5'h1;
      if (rx_pop && rxq.size() != 0)
        void'(rxq.pop_front());
    end
    engine_done <= !reset && cnt == 5'h1;
    rx_byte_done <= !reset && cnt == 5'h1 && rd;
    tx_push_ready <= txq.size() < 8;
    tx_valid <= txq.size() != 0;
    tx_data <= txq.size() != 0 ? txq[0] : junk;
    rx_valid <= rxq.size() != 0;
    {rx_first, rx_data} <= rxq.size() != 0 ? rxq[0] : junk[8:0];
  end
endmodule
`default_nettype wire

// File: i2coa_pkg.sv
// constants for the own-address and data/command port block
// Functional notes
// - own address is bits 9:0, upper bits reserved, resets to 0x055.
// - 7-bit addressing compares only own address bits 6:0.
// - own address writes land only while controller enable bit 0 is clear.
// - write width 11 or 9 bits, read width 12 or 8, per option.
// - each port write pushes a transmit entry, each read pops a byte if one is held, else returns zero.
// - acknowledge incoming bytes only while a queued read command is pending; as slave, bytes are always acknowledged.
// - read bit 11 flags the first byte after the address phase.
// - restart bit set with repeated start enabled forces a repeated start.
// - restart bit clear: repeated start only when direction changes.
// - repeated start disabled: stop then start replaces any repeated start.
// - restart bit is self-clearing per command, resets to zero.
// - bit 8 selects master read or write, ignored as slave.
// - bit 9 issues stop after byte; else empty fifo holds clock low.
// - bits 7:0 carry transmit byte on writes, received byte on reads.
`default_nettype none
package i2coa_pkg;
  localparam logic [7:0] OFS_OWN_ADDR = 8'h08;
  localparam logic [7:0] OFS_DATA_CMD = 8'h10;
  localparam int OWN_ADDR_W = 10;
  localparam logic [9:0] OWN_ADDR_RESET = 10'h055;
  localparam int SEVEN_BIT_W = 7;
  localparam int BIT_FIRST = 11;
  localparam int BIT_RESTART = 10;
  localparam int BIT_STOP = 9;
  localparam int BIT_CMD = 8;
  localparam int CMD_W = 11;
  localparam int PEND_W = 6;
  localparam logic [5:0] PEND_MAX = 6'h3f;
  localparam logic [10:0] CMD_MASK_HOLD = 11'h7ff;
  localparam logic [10:0] CMD_MASK_PLAIN = 11'h1ff;
  typedef enum logic [1:0] {
    I2COA_IDLE = 2'b00,
    I2COA_BUSY = 2'b01,
    I2COA_HOLD = 2'b10
  } i2coa_seq_t;
endpackage
`default_nettype wire

// File: i2coa_port.sv
// own slave address register and data/command port behind the apb slave
`default_nettype none
module i2coa_port
  import i2coa_pkg::*;
#(
  parameter bit EMPTY_FIFO_HOLD_OPTION = 1'b1,
  parameter bit FIRST_BYTE_STATUS_OPTION = 1'b1
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic controller_enable,
  input wire logic ten_bit_slave,
  input wire logic master_mode,
  input wire logic repeated_start_enable,
  output logic tx_push_valid,
  output logic [CMD_W-1:0] tx_push_data,
  input wire logic tx_push_ready,
  input wire logic tx_valid,
  input wire logic [CMD_W-1:0] tx_data,
  output logic tx_pop,
  input wire logic engine_ready,
  input wire logic engine_done,
  output logic issue_restart,
  output logic issue_stop_start,
  output logic dir_read,
  output logic stop_after,
  output logic [7:0] tx_byte,
  output logic hold_scl_low,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_first,
  output logic rx_pop,
  input wire logic rx_byte_done,
  output logic rx_ack_enable,
  input wire logic [OWN_ADDR_W-1:0] seen_address,
  output logic address_match
);
  typedef struct packed {
    logic [OWN_ADDR_W-1:0] own_addr;
    logic [31:0] rdata;
    logic [PEND_W-1:0] pending;
    logic match;
  } i2coa_st_t;
  i2coa_st_t s_q, s_d;
  logic setup;
  logic access;
  logic hit_addr;
  logic hit_data;
  logic push_read;

  function automatic logic [CMD_W-1:0] cmd_mask(input logic hold_opt);
    cmd_mask = hold_opt ? CMD_MASK_HOLD : CMD_MASK_PLAIN;
  endfunction

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign hit_addr = paddr == OFS_OWN_ADDR;
  assign hit_data = paddr == OFS_DATA_CMD;
  // a write into a full fifo stalls the bus rather than losing the entry
  assign pready = !(hit_data && pwrite && !tx_push_ready);
  assign pslverr = 1'b0;
  assign tx_push_valid = access && pwrite && hit_data;
  assign tx_push_data = pwdata[CMD_W-1:0] & cmd_mask(EMPTY_FIFO_HOLD_OPTION);
  assign push_read = tx_push_valid && tx_push_ready && master_mode && tx_push_data[BIT_CMD];
  // pop at setup so read data is in a flop by the access phase
  assign rx_pop = setup && !pwrite && hit_data && rx_valid;

  always_comb
  begin
    s_d = s_q;
    if (access && pwrite && hit_addr && !controller_enable)
      s_d.own_addr = pwdata[OWN_ADDR_W-1:0];
    if (setup && !pwrite)
    begin
      s_d.rdata = '0;
      if (hit_addr)
        s_d.rdata[OWN_ADDR_W-1:0] = s_q.own_addr;
      else if (hit_data && rx_valid)
      begin
        s_d.rdata[7:0] = rx_data;
        s_d.rdata[BIT_FIRST] = FIRST_BYTE_STATUS_OPTION && rx_first;
      end
    end
    // count queued read commands against bytes actually received
    if (push_read && !rx_byte_done && s_q.pending != PEND_MAX)
      s_d.pending = s_q.pending + 1'b1;
    else if (rx_byte_done && !push_read && s_q.pending != '0)
      s_d.pending = s_q.pending - 1'b1;
    if (ten_bit_slave)
      s_d.match = seen_address == s_q.own_addr;
    else
      s_d.match = seen_address[SEVEN_BIT_W-1:0] == s_q.own_addr[SEVEN_BIT_W-1:0];
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      s_q <= '0;
      s_q.own_addr <= OWN_ADDR_RESET;
    end
    else
      s_q <= s_d;
  end

  assign prdata = s_q.rdata;
  assign address_match = s_q.match;
  // master reads stop being acked once no read command remains
  assign rx_ack_enable = !master_mode || s_q.pending != '0;

  i2coa_cmd_seq i2coa_cmd_seq_i (
    .clock(clock),
    .reset(reset),
    .master_mode(master_mode),
    .repeated_start_enable(repeated_start_enable),
    .cmd_valid(tx_valid),
    .cmd_data(tx_data),
    .engine_ready(engine_ready),
    .engine_done(engine_done),
    .cmd_take(tx_pop),
    .issue_restart(issue_restart),
    .issue_stop_start(issue_stop_start),
    .dir_read(dir_read),
    .stop_after(stop_after),
    .tx_byte(tx_byte),
    .hold_scl_low(hold_scl_low)
  );

  ////////////////////////////////////////////////////////////////////////////
  property p_no_write_enabled;
    @(posedge clock) disable iff (reset) controller_enable |=> $stable(s_q.own_addr);
  endproperty
  a_no_write_enabled: assert property (p_no_write_enabled) else $error("own address changed while enabled");
  property p_write_disabled;
    @(posedge clock) disable iff (reset)
      access && pwrite && hit_addr && !controller_enable |=> s_q.own_addr == $past(pwdata[OWN_ADDR_W-1:0]);
  endproperty
  a_write_disabled: assert property (p_write_disabled) else $error("own address write lost");
  property p_reserved_zero;
    @(posedge clock) disable iff (reset) s_q.rdata[31:BIT_FIRST+1] == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved read bits set");
  property p_read_byte;
    @(posedge clock) disable iff (reset) rx_pop |=> prdata[7:0] == $past(rx_data);
  endproperty
  a_read_byte: assert property (p_read_byte) else $error("popped byte not returned");
  property p_first_flag;
    @(posedge clock) disable iff (reset) rx_pop |=> prdata[BIT_FIRST] == (FIRST_BYTE_STATUS_OPTION && $past(rx_first));
  endproperty
  a_first_flag: assert property (p_first_flag) else $error("first byte flag wrong");
  property p_seven_bit;
    @(posedge clock) disable iff (reset)
      !ten_bit_slave && seen_address[SEVEN_BIT_W-1:0] == s_q.own_addr[SEVEN_BIT_W-1:0] ##1 !ten_bit_slave
      |-> address_match;
  endproperty
  a_seven_bit: assert property (p_seven_bit) else $error("7-bit address miss");
  property p_ack_stop;
    @(posedge clock) disable iff (reset) master_mode && s_q.pending == '0 |-> !rx_ack_enable;
  endproperty
  a_ack_stop: assert property (p_ack_stop) else $error("ack without pending read");
  property p_push_mask;
    @(posedge clock) disable iff (reset) tx_push_valid && !EMPTY_FIFO_HOLD_OPTION |-> tx_push_data[10:9] == 2'b00;
  endproperty
  a_push_mask: assert property (p_push_mask) else $error("hold bits pushed without option");
  property p_pop_single;
    @(posedge clock) disable iff (reset) rx_pop |=> !rx_pop;
  endproperty
  a_pop_single: assert property (p_pop_single) else $error("receive fifo popped twice");
  property p_empty_read;
    @(posedge clock) disable iff (reset) setup && !pwrite && hit_data && !rx_valid |=> prdata == '0;
  endproperty
  a_empty_read: assert property (p_empty_read) else $error("empty port read not zero");
  property p_addr_read;
    @(posedge clock) disable iff (reset) setup && !pwrite && hit_addr |=> prdata == {22'h0, $past(s_q.own_addr)};
  endproperty
  a_addr_read: assert property (p_addr_read) else $error("own address read wrong");
  property p_rdata_stands;
    @(posedge clock) disable iff (reset) !(setup && !pwrite) |=> $stable(prdata);
  endproperty
  a_rdata_stands: assert property (p_rdata_stands) else $error("read data moved outside a read");
  property p_pending_up;
    @(posedge clock) disable iff (reset)
      push_read && !rx_byte_done && s_q.pending != PEND_MAX |=> s_q.pending == $past(s_q.pending) + 6'h01;
  endproperty
  a_pending_up: assert property (p_pending_up) else $error("read command not counted");
  property p_pending_down;
    @(posedge clock) disable iff (reset)
      rx_byte_done && !push_read && s_q.pending != '0 |=> s_q.pending == $past(s_q.pending) - 6'h01;
  endproperty
  a_pending_down: assert property (p_pending_down) else $error("received byte not retired");
  property p_ready_read;
    @(posedge clock) disable iff (reset) access && !pwrite |-> pready;
  endproperty
  a_ready_read: assert property (p_ready_read) else $error("read stalled");
  property p_ten_bit;
    @(posedge clock) disable iff (reset) ten_bit_slave && seen_address == s_q.own_addr ##1 ten_bit_slave |-> address_match;
  endproperty
  a_ten_bit: assert property (p_ten_bit) else $error("10-bit address miss");
  property p_ten_miss;
    @(posedge clock) disable iff (reset) ten_bit_slave && seen_address != s_q.own_addr ##1 ten_bit_slave |-> !address_match;
  endproperty
  a_ten_miss: assert property (p_ten_miss) else $error("10-bit false match");
  property p_seven_miss;
    @(posedge clock) disable iff (reset)
      !ten_bit_slave && seen_address[SEVEN_BIT_W-1:0] != s_q.own_addr[SEVEN_BIT_W-1:0] ##1 !ten_bit_slave |-> !address_match;
  endproperty
  a_seven_miss: assert property (p_seven_miss) else $error("7-bit false match");
  property p_own_stable;
    @(posedge clock) disable iff (reset) !(access && pwrite && hit_addr) |=> $stable(s_q.own_addr);
  endproperty
  a_own_stable: assert property (p_own_stable) else $error("own address moved without a write");
  property p_write_data;
    @(posedge clock) disable iff (reset) tx_push_valid |-> tx_push_data[8:0] == pwdata[8:0];
  endproperty
  a_write_data: assert property (p_write_data) else $error("pushed command differs from write");
endmodule
`default_nettype wire

// File: i2coa_port_test.sv
// self-checking bench for the own-address and data/command port
`default_nettype none
module i2coa_port_test;
  import i2coa_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic controller_enable = 1'h0, ten_bit_slave = 1'h0, master_mode = 1'h1, repeated_start_enable = 1'h1;
  logic stall = 1'h0, open = 1'h0, pdir = 1'h0, pop_seen = 1'h0;
  logic [7:0] paddr = 8'h0, tx_byte, rx_data, b0, b1;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [9:0] seen_address = 10'h0;
  logic [3:0] lat = 4'h0;
  logic pready, pslverr, tx_push_valid, tx_push_ready, tx_valid, tx_pop, engine_ready, engine_done;
  logic issue_restart, issue_stop_start, dir_read, stop_after, hold_scl_low, rx_valid, rx_first, rx_pop;
  logic rx_byte_done, rx_ack_enable, address_match;
  logic [CMD_W-1:0] tx_push_data, tx_data;
  logic [31:0] rq[$];
  logic [23:0] sq[$];
  logic [23:0] s;
  logic [10:0] tbl[9] = '{11'h000, 11'h100, 11'h500, 11'h100, 11'h000, 11'h400, 11'h300, 11'h100, 11'h200};
  int fails = 0, cmp_count = 0, seed = 32'haa2d2754;
  i2coa_port i2coa_port_i (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .controller_enable, .ten_bit_slave, .master_mode, .repeated_start_enable, .tx_push_valid,
    .tx_push_data, .tx_push_ready, .tx_valid, .tx_data, .tx_pop, .engine_ready, .engine_done, .issue_restart,
    .issue_stop_start, .dir_read, .stop_after, .tx_byte, .hold_scl_low, .rx_valid, .rx_data, .rx_first,
    .rx_pop, .rx_byte_done, .rx_ack_enable, .seen_address, .address_match);
  i2coa_far i2coa_far_i (.clock, .reset, .stall, .lat, .tx_push_valid, .tx_push_data, .tx_push_ready,
    .tx_valid, .tx_data, .tx_pop, .engine_ready, .engine_done, .rx_valid, .rx_data, .rx_first, .rx_pop,
    .rx_byte_done);
  initial forever #10 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (fails == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock) #1;
    penable <= 1'h1;
    // hold the access until pready is seen high at an edge
    for (n = 0; n < 100 && !pready; n++)
      @(posedge clock) #1;
    if (n == 100)
    begin
      fails++;
      close_out();
    end
    @(posedge clock) #1;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock) #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rq.push_back(exp);
    apb(1'h0, a, 32'h0);
  endtask
  task automatic cmd(input logic [10:0] c);
    logic need;
    need = open && (c[BIT_RESTART] || c[BIT_CMD] != pdir);
    sq.push_back({4'hf, {8{!c[8]}}, need && repeated_start_enable, need && !repeated_start_enable,
      c[8], c[9], c[8] ? 8'h0 : c[7:0]});
    open = !c[BIT_STOP];
    pdir = c[BIT_CMD];
    lat <= 4'($random(seed));
    apb(1'h1, OFS_DATA_CMD, {21'h0, c});
  endtask
  task automatic wait_idle();
    int n;
    for (n = 0; n < 500 && (tx_valid || !engine_ready); n++)
      @(posedge clock) #1;
    if (n == 500)
    begin
      fails++;
      close_out();
    end
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic settle_chk(input logic [31:0] seen_addr, input logic exp);
    seen_address <= seen_addr[9:0];
    repeat (2) @(posedge clock);
    #1;
    chk(address_match, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clock)
  begin
    if (psel && penable && pready && !pwrite)
      chk(prdata, rq.pop_front());
    if (psel && penable && pready)
      chk(pslverr, 1'h0);
    if (pop_seen && sq.size() != 0)
    begin
      s = sq.pop_front();
      chk({issue_restart, issue_stop_start, dir_read, stop_after, tx_byte} & s[23:12], s[11:0]);
    end
    pop_seen = tx_pop;
  end
  initial
  begin
    repeat (16) @(posedge clock);
    #1;
    reset <= 1'h0;
    rd(OFS_OWN_ADDR, 32'h055);
    apb(1'h1, OFS_OWN_ADDR, 32'hfffff3aa);
    rd(OFS_OWN_ADDR, 32'h3aa);
    controller_enable <= 1'h1;
    apb(1'h1, OFS_OWN_ADDR, 32'h12);
    rd(OFS_OWN_ADDR, 32'h3aa);
    rd(8'h20, 32'h0);
    settle_chk(32'h12a, 1'h1);
    ten_bit_slave <= 1'h1;
    settle_chk(32'h12a, 1'h0);
    settle_chk(32'h3aa, 1'h1);
    // a stalled engine keeps the read command pending
    stall <= 1'h1;
    cmd(11'h300);
    chk(rx_ack_enable, 1'h1);
    stall <= 1'h0;
    wait_idle();
    chk(rx_ack_enable, 1'h0);
    b0 = 8'($random(seed));
    b1 = 8'($random(seed));
    i2coa_far_i.rx_put({1'h1, b0});
    i2coa_far_i.rx_put({1'h0, b1});
    repeat (2) @(posedge clock);
    #1;
    rd(OFS_DATA_CMD, {20'h0, 4'h8, b0});
    rd(OFS_DATA_CMD, {24'h0, b1});
    rd(OFS_DATA_CMD, 32'h0);
    for (int i = 0; i < 9; i++)
    begin
      if (i == 5)
      begin
        wait_idle();
        chk(hold_scl_low, 1'h1);
        // blocking, so the expectation of the next command already sees it off
        repeated_start_enable = 1'h0;
      end
      cmd(tbl[i] | {3'h0, 8'($random(seed))});
    end
    wait_idle();
    chk(hold_scl_low, 1'h0);
    close_out();
  end
endmodule
`default_nettype wire
